// *** bench/testbench.sv ***
// self-checking testbench of the trap and vector logic
`timescale 1ns/1ns
module testbench;
    import tvl_pkg::*;
    logic              clk = 1'b0;
    logic              srst = 1'b1;
    logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]       paddr = 12'h000;
    logic [31:0]       pwdata = 32'h0, prdata, r;
    logic              pready, pslverr, e;
    logic [NODES-1:0]  node_event = '0;
    logic [10:0]       trig = '0;
    logic              sw_trap_req = 1'b0, trap_return = 1'b0;
    logic [TN_W-1:0]   sw_trap_num = 7'h00, branch_trap_num;
    logic [PRIO_W-1:0] cpu_prio = 4'h0, branch_prio, ack_dly = 4'h0;
    logic              branch_ack, branch_valid, sw_trap_grant, irq;
    logic [VEC_W-1:0]  branch_vector;
    logic [TN_W-1:0]   a_tn [3] = '{TN_NMI, TN_STKO, TN_STKU};
    int                n_fail = 0, num_checks = 0;

    always #4 clk = ~clk;

    // trig: 0 hw reset, 1 sw reset, 2 watchdog, 3 nmi, 4/5 stack, 6..10 class b
    tvl_core u_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .node_event(node_event),
        .hw_reset_req(trig[0]), .sw_reset_req(trig[1]), .wdog_overflow(trig[2]),
        .nmi_event(trig[3]), .stack_over_event(trig[4]),
        .stack_under_event(trig[5]), .class_b_event(trig[10:6]),
        .sw_trap_req(sw_trap_req), .sw_trap_num(sw_trap_num),
        .sw_trap_grant(sw_trap_grant), .cpu_prio(cpu_prio),
        .trap_return(trap_return), .branch_ack(branch_ack),
        .branch_valid(branch_valid), .branch_vector(branch_vector),
        .branch_trap_num(branch_trap_num), .branch_prio(branch_prio), .irq(irq));

    tvl_cpu_model u_cpu (.clk(clk), .srst(srst), .branch_valid(branch_valid),
        .ack_dly(ack_dly), .branch_ack(branch_ack));

    // ==========================================================
    // tasks
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        num_checks++;
        if (got !== ex) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    // apb transfer; waits on pready, the watchdog ends a hang
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0);
        chk("read data", ex, r);
    endtask : rd

    task automatic fire(input logic [10:0] v);
        @(posedge clk);
        trig <= v;
        @(posedge clk);
        trig <= '0;
    endtask : fire

    task automatic ret();
        @(posedge clk);
        trap_return <= 1'b1;
        @(posedge clk);
        trap_return <= 1'b0;
    endtask : ret

    // sampled at the edge where the pipeline takes the branch
    task automatic take(input logic [TN_W-1:0] tn, input logic [PRIO_W-1:0] pr);
        int i;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (!(branch_valid === 1'b1 && branch_ack === 1'b1) && i < 60);
        chk("branch taken", 32'h1, {31'h0, branch_valid && branch_ack});
        chk("trap number", {25'h0, tn}, {25'h0, branch_trap_num});
        chk("vector", {23'h0, tn, 2'b00}, {16'h0, branch_vector});
        chk("priority", {28'h0, pr}, {28'h0, branch_prio});
        chk("sw grant", {31'h0, sw_trap_req}, {31'h0, sw_trap_grant});
        sw_trap_req <= 1'b0;
    endtask : take

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim

    // ==========================================================
    // tests
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        rd(ADDR_FLAGS, 32'h0);
        rd(ADDR_MASK, 32'h0);
        apb(1'b0, 12'hFFC, 32'h0);
        chk("slave error", 32'h1, {31'h0, e});
        apb(1'b1, ADDR_MASK, 32'hFF);
        rd(ADDR_MASK, 32'hFF);
        for (int i = 0; i < 3; i++) begin
            fire(11'h8 << i);
            take(a_tn[i], TRAP_PRIO);
            chk("irq", 32'h1, {31'h0, irq});
            rd(ADDR_FLAGS, 32'h1 << i);
            ret();
            chk("irq", 32'h0, {31'h0, irq});
        end
        ack_dly <= 4'h3;
        for (int i = 0; i < 5; i++) begin
            fire(11'h40 << i);
            take(TN_CLASSB, TRAP_PRIO);
            rd(ADDR_FLAGS, 32'h8 << i);
            ret();
        end
        ack_dly <= 4'h0;
        for (int i = 0; i < 3; i++) begin
            fire(11'h1 << i);
            take(TN_RESET, TRAP_PRIO);
            rd(ADDR_FLAGS, 32'h0);
            ret();
        end
        // preemption by higher class, then simultaneous traps
        apb(1'b1, ADDR_MASK, 32'h0);
        fire(11'h40);
        take(TN_CLASSB, TRAP_PRIO);
        fire(11'h8);
        take(TN_NMI, TRAP_PRIO);
        fire(11'h1);
        take(TN_RESET, TRAP_PRIO);
        ret();
        fire(11'h48);
        take(TN_NMI, TRAP_PRIO);
        ret();
        take(TN_CLASSB, TRAP_PRIO);
        ret();
        chk("irq", 32'h0, {31'h0, irq});
        rd(ADDR_FLAGS, 32'h9);
        cpu_prio <= 4'h3;
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            sw_trap_num <= (k == 0) ? 7'h7F : 7'h00;
            sw_trap_req <= 1'b1;
            take((k == 0) ? 7'h7F : 7'h00, 4'h3);
        end
        // node request raised by software while a trap service runs
        fire(11'h8);
        take(TN_NMI, TRAP_PRIO);
        rd(ADDR_STATE, 32'h2);
        cpu_prio <= 4'h9;
        apb(1'b1, ADDR_NODE0 + 12'h004, 32'hC9);
        repeat (10) @(posedge clk) chk("branch valid", 32'h0, {31'h0, branch_valid});
        ret();
        repeat (10) @(posedge clk) chk("branch valid", 32'h0, {31'h0, branch_valid});
        cpu_prio <= 4'h4;
        take(7'h46, 4'h9);
        cpu_prio <= 4'h0;
        apb(1'b1, ADDR_NODE0, 32'h41);
        apb(1'b1, ADDR_NODE0 + 12'h064, 32'h42);
        @(posedge clk);
        node_event <= 26'h2000001;
        @(posedge clk);
        node_event <= '0;
        take(7'h43, 4'h2);
        take(7'h45, 4'h1);
        rd(ADDR_NODE0, 32'h41);
        end_sim();
    end

    // the tests need a few hundred cycles
    initial begin
        #200000;
        n_fail++;
        end_sim();
    end
endmodule : testbench

// *** bench/tvl_cpu_model.sv ***
// cpu pipeline model that takes branch requests from the trap logic
`timescale 1ns/1ns
module tvl_cpu_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // branch handshake
    input  wire logic       branch_valid,
    input  wire logic [3:0] ack_dly,
    output logic            branch_ack
);
    int wait_cnt;

    // ==========================================================
    // take a branch after ack_dly cycles; ack drops after the taking edge
    always_ff @(posedge clk) begin
        if (srst || !branch_valid || branch_ack) begin
            branch_ack <= 1'b0;
            wait_cnt   <= 0;
        end else if (wait_cnt >= int'(ack_dly)) begin
            branch_ack <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 1;
        end
    end
endmodule : tvl_cpu_model

// *** src/tvl_core.sv ***
// trap and vector logic: node flags, hardware traps, branch requests
//
// What this block does
// - every node has its own request flag, enable flag, vector and trap number.
// - a hardware trap branches to the vector of its trap number at once and cannot be masked.
// - each hardware trap except the reset functions sets its own bit in the exception flag register.
// - a hardware trap preempts anything except a trap service of equal or higher class.
// - standard interrupts are held off while a class A or class B trap service runs; a reset service does not hold them off.
// - all reset functions branch to vector 0 with trap number 0 and set no flag.
// - nmi, stack overflow and stack underflow each have their own vector and flag.
// - all class B faults share one vector, each with its own flag.
// - software traps accept any trap number up to 7F and run at current priority.
// - each node has a four bit priority; only a higher priority preempts.
// - software may raise a node request by writing its request bit to one.
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module tvl_core
    import tvl_pkg::*;
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               srst,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic                    pready,
    output logic                    pslverr,
    output logic [31:0]             prdata,
    // peripheral request pulses
    input  wire logic [NODES-1:0]   node_event,
    // trap conditions, one-cycle pulses
    input  wire logic               hw_reset_req,
    input  wire logic               sw_reset_req,
    input  wire logic               wdog_overflow,
    input  wire logic               nmi_event,
    input  wire logic               stack_over_event,
    input  wire logic               stack_under_event,
    input  wire logic [B_COUNT-1:0] class_b_event,
    // software trap from the pipeline
    input  wire logic               sw_trap_req,
    input  wire logic [TN_W-1:0]    sw_trap_num,
    output logic                    sw_trap_grant,
    // cpu pipeline
    input  wire logic [PRIO_W-1:0]  cpu_prio,
    input  wire logic               trap_return,
    input  wire logic               branch_ack,
    output logic                    branch_valid,
    output logic [VEC_W-1:0]        branch_vector,
    output logic [TN_W-1:0]         branch_trap_num,
    output logic [PRIO_W-1:0]       branch_prio,
    // interrupt
    output logic                    irq
);
    // ==========================================================
    // state
    logic [NODES-1:0]  node_req;
    logic [NODES-1:0]  node_en;
    logic [PRIO_W-1:0] node_prio [NODES];
    logic [FLAG_W-1:0] exception_flag_register;
    logic [FLAG_W-1:0] flag_mask;
    logic [FLAG_W-1:0] read_snap;
    logic              reset_pend;
    logic [2:0]        a_pend;
    logic [B_COUNT-1:0] b_pend;
    tvl_class_t        trap_level;
    tvl_class_t        sel_class;
    tvl_class_t        held_class;
    tvl_kind_t         held_kind;
    tvl_state_t        state;
    logic [TN_W-1:0]   sel_num;
    logic [NODE_W-1:0] held_node;
    logic              int_any;
    logic [NODE_W-1:0] int_idx;
    logic [PRIO_W-1:0] int_prio;

    // ==========================================================
    // apb decode
    logic        setup;
    logic        access;
    logic        wr_en;
    logic        node_hit;
    logic [11:0] node_off;
    logic [NODE_W-1:0] wr_node;
    logic        mapped;

    assign setup    = psel && !penable;
    assign access   = psel && penable;
    assign node_off = paddr - ADDR_NODE0;
    assign wr_node  = node_off[NODE_W+1:2];
    assign node_hit = (paddr >= ADDR_NODE0) && (node_off[11:2] < 10'(NODES))
                      && (paddr[1:0] == 2'b00);
    assign mapped   = node_hit || paddr == ADDR_FLAGS || paddr == ADDR_MASK
                      || paddr == ADDR_STATE;
    assign wr_en    = access && pwrite && mapped;
    assign pready   = 1'b1;
    assign pslverr  = access && !mapped;

    // read data is captured in setup so it comes from a flop with no wait state
    always_ff @(posedge clk) begin
        if (srst) begin
            prdata    <= '0;
            read_snap <= '0;
        end else if (setup) begin
            prdata    <= '0;
            read_snap <= '0;
            if (!pwrite) begin
                if (paddr == ADDR_FLAGS) begin
                    prdata[FLAG_W-1:0] <= exception_flag_register;
                    read_snap          <= exception_flag_register;
                end else if (paddr == ADDR_MASK) begin
                    prdata[FLAG_W-1:0] <= flag_mask;
                end else if (paddr == ADDR_STATE) begin
                    prdata[1:0] <= trap_level;
                    prdata[2]   <= branch_valid;
                end else if (node_hit) begin
                    prdata[NC_REQ_BIT]   <= node_req[wr_node];
                    prdata[NC_EN_BIT]    <= node_en[wr_node];
                    prdata[PRIO_W-1:0]   <= node_prio[wr_node];
                end
            end
        end
    end

    // ==========================================================
    // node control registers
    logic ack_int;
    assign ack_int = branch_valid && branch_ack && held_kind == KD_INT;

    for (genvar n = 0; n < NODES; n++) begin : g_node
        logic wr_this;
        assign wr_this = wr_en && node_hit && wr_node == NODE_W'(n);
        // a hardware or software set beats a clear in the same cycle
        always_ff @(posedge clk) begin
            if (srst) begin
                node_req[n] <= 1'b0;
            end else if (node_event[n]) begin
                node_req[n] <= 1'b1;
            end else if (wr_this) begin
                node_req[n] <= pwdata[NC_REQ_BIT];
            end else if (ack_int && held_node == NODE_W'(n)) begin
                node_req[n] <= 1'b0;
            end
        end
        always_ff @(posedge clk) begin
            if (srst) begin
                node_en[n]   <= 1'b0;
                node_prio[n] <= '0;
            end else if (wr_this) begin
                node_en[n]   <= pwdata[NC_EN_BIT];
                node_prio[n] <= pwdata[PRIO_W-1:0];
            end
        end
    end

    // ==========================================================
    // exception flags, mask and interrupt
    logic [FLAG_W-1:0] flag_set;
    assign flag_set = {class_b_event, stack_under_event, stack_over_event, nmi_event};

    always_ff @(posedge clk) begin
        if (srst) begin
            exception_flag_register <= '0;
        end else begin
            // bits read this transfer clear, new events still land
            exception_flag_register <= (exception_flag_register
                & ~((access && !pwrite && paddr == ADDR_FLAGS) ? read_snap : '0))
                | flag_set;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            flag_mask <= MASK_RST;
        end else if (wr_en && paddr == ADDR_MASK) begin
            flag_mask <= pwdata[FLAG_W-1:0];
        end
    end

    assign irq = |(exception_flag_register & flag_mask);

    // ==========================================================
    // pending hardware traps
    logic take_trap;
    assign take_trap = branch_valid && branch_ack && held_kind == KD_HW;

    always_ff @(posedge clk) begin
        if (srst) begin
            reset_pend <= 1'b0;
            a_pend     <= '0;
            b_pend     <= '0;
        end else begin
            reset_pend <= (hw_reset_req || sw_reset_req || wdog_overflow)
                || (reset_pend && !(take_trap && held_class == CL_RESET));
            if (take_trap && held_class == CL_RESET) begin
                a_pend <= flag_set[FLG_STKU:FLG_NMI];
                b_pend <= class_b_event;
            end else begin
                a_pend <= (a_pend & ~((take_trap && held_class == CL_A)
                          ? (branch_trap_num == TN_NMI ? 3'h1
                             : branch_trap_num == TN_STKO ? 3'h2 : 3'h4)
                          : 3'h0)) | flag_set[FLG_STKU:FLG_NMI];
                b_pend <= (take_trap && held_class == CL_B) ? class_b_event
                          : (b_pend | class_b_event);
            end
        end
    end

    tvl_trap_select u_trap_select (
        .reset_pend (reset_pend),
        .a_pend     (a_pend),
        .b_pend     (b_pend),
        .sel_class  (sel_class),
        .sel_num    (sel_num)
    );

    tvl_node_arbiter u_node_arbiter (
        .req      (node_req),
        .en       (node_en),
        .prio     (node_prio),
        .any      (int_any),
        .idx      (int_idx),
        .win_prio (int_prio)
    );

    // ==========================================================
    // branch request
    logic trap_go;
    logic int_go;
    assign trap_go = sel_class > trap_level || sel_class == CL_RESET;
    assign int_go  = int_any && trap_level == CL_NONE
                     && int_prio > cpu_prio;
    assign sw_trap_grant = branch_valid && branch_ack && held_kind == KD_SW;

    always_ff @(posedge clk) begin
        if (srst) begin
            state           <= ST_IDLE;
            branch_valid    <= 1'b0;
            branch_vector   <= '0;
            branch_trap_num <= '0;
            branch_prio     <= '0;
            held_kind       <= KD_HW;
            held_class      <= CL_NONE;
            held_node       <= '0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (trap_go && sel_class != CL_NONE) begin
                        branch_valid    <= 1'b1;
                        branch_trap_num <= sel_num;
                        branch_vector   <= VEC_W'({sel_num, 2'b00});
                        branch_prio     <= TRAP_PRIO;
                        held_kind       <= KD_HW;
                        held_class      <= sel_class;
                        state           <= ST_ISSUE;
                    end else if (sw_trap_req) begin
                        branch_valid    <= 1'b1;
                        branch_trap_num <= sw_trap_num;
                        branch_vector   <= VEC_W'({sw_trap_num, 2'b00});
                        branch_prio     <= cpu_prio;
                        held_kind       <= KD_SW;
                        state           <= ST_ISSUE;
                    end else if (int_go) begin
                        branch_valid    <= 1'b1;
                        branch_trap_num <= NODE_TRAP[int_idx];
                        branch_vector   <= VEC_W'({NODE_TRAP[int_idx], 2'b00});
                        branch_prio     <= int_prio;
                        held_kind       <= KD_INT;
                        held_node       <= int_idx;
                        state           <= ST_ISSUE;
                    end
                end
                ST_ISSUE: begin
                    // request stands until the pipeline takes it
                    if (branch_ack) begin
                        branch_valid <= 1'b0;
                        state        <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // class of the running trap service; a reset restarts from none
    always_ff @(posedge clk) begin
        if (srst) begin
            trap_level <= CL_NONE;
        end else if (take_trap) begin
            trap_level <= (held_class == CL_RESET) ? CL_NONE : held_class;
        end else if (trap_return) begin
            trap_level <= CL_NONE;
        end
    end

    // ==========================================================
    // checks
    trap_vector_a: assert property (@(posedge clk) disable iff (srst)
        branch_valid |-> branch_vector == VEC_W'({branch_trap_num, 2'b00}))
        else $error("vector not four times trap number");
    reset_vector_a: assert property (@(posedge clk) disable iff (srst)
        branch_valid && held_class == CL_RESET && held_kind == KD_HW
        |-> branch_trap_num == TN_RESET)
        else $error("reset branch not to trap zero");
    flag_set_a: assert property (@(posedge clk) disable iff (srst)
        nmi_event |=> exception_flag_register[FLG_NMI])
        else $error("nmi flag not set");
    nmi_branch_a: assert property (@(posedge clk) disable iff (srst)
        nmi_event && state == ST_IDLE && !reset_pend && trap_level < CL_A
        ##1 state == ST_IDLE |=> branch_valid && branch_trap_num == TN_NMI)
        else $error("nmi not branched");
    int_blocked_a: assert property (@(posedge clk) disable iff (srst)
        $rose(branch_valid) && held_kind == KD_INT |-> $past(trap_level) == CL_NONE)
        else $error("interrupt during trap service");
    int_prio_a: assert property (@(posedge clk) disable iff (srst)
        $rose(branch_valid) && held_kind == KD_INT
        |-> branch_prio > $past(cpu_prio))
        else $error("interrupt without higher priority");
    sw_prio_a: assert property (@(posedge clk) disable iff (srst)
        $rose(branch_valid) && held_kind == KD_SW
        |-> branch_prio == $past(cpu_prio) && branch_trap_num == $past(sw_trap_num))
        else $error("software trap priority wrong");
    class_b_a: assert property (@(posedge clk) disable iff (srst)
        branch_valid && held_class == CL_B && held_kind == KD_HW
        |-> branch_trap_num == TN_CLASSB)
        else $error("class b trap number wrong");
    preempt_a: assert property (@(posedge clk) disable iff (srst)
        $rose(branch_valid) && held_kind == KD_HW && held_class != CL_RESET
        |-> held_class > $past(trap_level))
        else $error("trap preempted equal or higher class");
    order_a: assert property (@(posedge clk) disable iff (srst)
        $rose(branch_valid) && held_kind == KD_HW && $past(reset_pend)
        |-> held_class == CL_RESET)
        else $error("reset not served first");
    stack_a: assert property (@(posedge clk) disable iff (srst)
        $rose(branch_valid) && held_kind == KD_HW && branch_trap_num == TN_STKO
        |-> $past(a_pend[1]) && !$past(a_pend[0]))
        else $error("stack trap order wrong");
    sw_set_a: assert property (@(posedge clk) disable iff (srst)
        wr_en && node_hit && pwdata[NC_REQ_BIT] |=> node_req[$past(wr_node)])
        else $error("software node request lost");
endmodule : tvl_core

// *** src/tvl_node_arbiter.sv ***
// picks the enabled pending node of highest priority
`timescale 1ns/1ns
module tvl_node_arbiter
    import tvl_pkg::*;
(
    // node state
    input  wire logic [NODES-1:0]  req,
    input  wire logic [NODES-1:0]  en,
    input  wire logic [PRIO_W-1:0] prio [NODES],
    // winner
    output logic                   any,
    output logic [NODE_W-1:0]      idx,
    output logic [PRIO_W-1:0]      win_prio
);
    // ties go to the lower node index
    always_comb begin
        any      = 1'b0;
        idx      = '0;
        win_prio = '0;
        for (int i = 0; i < NODES; i++) begin
            if (req[i] && en[i] && (!any || prio[i] > win_prio)) begin
                any      = 1'b1;
                idx      = NODE_W'(i);
                win_prio = prio[i];
            end
        end
    end
endmodule : tvl_node_arbiter

// *** src/tvl_pkg.sv ***
// constants and types shared by the trap and vector logic
package tvl_pkg;
    // ==========================================================
    // sizes
    localparam int NODES   = 26;
    localparam int NODE_W  = 5;
    localparam int PRIO_W  = 4;
    localparam int TN_W    = 7;
    localparam int VEC_W   = 16;
    localparam int FLAG_W  = 8;
    localparam int B_COUNT = 5;

    // ==========================================================
    // trap numbers of the fixed hardware traps
    localparam logic [TN_W-1:0] TN_RESET  = 7'h00;
    localparam logic [TN_W-1:0] TN_NMI    = 7'h02;
    localparam logic [TN_W-1:0] TN_STKO   = 7'h04;
    localparam logic [TN_W-1:0] TN_STKU   = 7'h06;
    localparam logic [TN_W-1:0] TN_CLASSB = 7'h0A;

    // trap number per interrupt node, node 0 first
    localparam logic [TN_W-1:0] NODE_TRAP [NODES] = '{
        7'h45, 7'h46, 7'h20, 7'h21, 7'h3D, 7'h3E, 7'h22, 7'h23, 7'h24,
        7'h25, 7'h26, 7'h27, 7'h28, 7'h29, 7'h2A, 7'h47, 7'h2B, 7'h2C,
        7'h2D, 7'h2E, 7'h2F, 7'h3F, 7'h40, 7'h41, 7'h42, 7'h43};
    localparam int NODE_CAPCOM30 = 0;
    localparam int NODE_CLK_RTC  = 25;

    // ==========================================================
    // register offsets
    localparam logic [11:0] ADDR_FLAGS = 12'h000;
    localparam logic [11:0] ADDR_MASK  = 12'h004;
    localparam logic [11:0] ADDR_STATE = 12'h008;
    localparam logic [11:0] ADDR_NODE0 = 12'h100;

    // node control fields
    localparam int NC_REQ_BIT = 7;
    localparam int NC_EN_BIT  = 6;

    // exception flag register bits
    localparam int FLG_NMI  = 0;
    localparam int FLG_STKO = 1;
    localparam int FLG_STKU = 2;
    localparam int FLG_B0   = 3;

    // mask reset value and hardware trap priority
    localparam logic [FLAG_W-1:0] MASK_RST = 8'h00;
    localparam logic [PRIO_W-1:0] TRAP_PRIO = 4'hF;

    // ==========================================================
    // types
    typedef enum logic [1:0] {CL_NONE, CL_B, CL_A, CL_RESET} tvl_class_t;
    typedef enum logic [1:0] {KD_HW, KD_SW, KD_INT} tvl_kind_t;
    typedef enum logic       {ST_IDLE, ST_ISSUE} tvl_state_t;
endpackage : tvl_pkg

// *** src/tvl_trap_select.sv ***
// fixed-order selection among pending hardware traps
`timescale 1ns/1ns
module tvl_trap_select
    import tvl_pkg::*;
(
    // pending traps
    input  wire logic               reset_pend,
    input  wire logic [2:0]         a_pend,
    input  wire logic [B_COUNT-1:0] b_pend,
    // selection
    output tvl_class_t              sel_class,
    output logic [TN_W-1:0]         sel_num
);
    always_comb begin
        sel_class = CL_NONE;
        sel_num   = TN_RESET;
        if (reset_pend) begin
            sel_class = CL_RESET;
            sel_num   = TN_RESET;
        end else if (a_pend[0]) begin
            sel_class = CL_A;
            sel_num   = TN_NMI;
        end else if (a_pend[1]) begin
            sel_class = CL_A;
            sel_num   = TN_STKO;
        end else if (a_pend[2]) begin
            sel_class = CL_A;
            sel_num   = TN_STKU;
        end else if (|b_pend) begin
            sel_class = CL_B;
            sel_num   = TN_CLASSB;
        end
    end
endmodule : tvl_trap_select
